/* src/dfr_pkg.sv */
// Constants and types for the disturbance and fault recorder control
package dfr_pkg;
  localparam int NTRIG = 8;
  localparam int NFUNC = 8;
  localparam int FIDW = $clog2(NFUNC);
  localparam int SPC = 32;
  localparam int LINE_HZ = 50;
  localparam int SAMPLE_HZ = LINE_HZ * SPC;
  localparam int STORE_S = 120;
  localparam int MAXREC_S = 15;
  localparam int CAP_TICKS = STORE_S * SAMPLE_HZ;
  localparam int MAX_TICKS = MAXREC_S * SAMPLE_HZ;
  localparam int FDEPTH = 20;
  localparam int TW = 24;
  localparam int PCT_FULL = 100;
  localparam logic [TW-1:0] LEN_RST = 24'h000640;
  localparam logic [6:0] PRE_RST = 7'h0a;
  localparam logic [6:0] POST_RST = 7'h14;
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_TRIG = 6'h04;
  localparam logic [5:0] OFS_LEN = 6'h08;
  localparam logic [5:0] OFS_PCT = 6'h0c;
  localparam logic [5:0] OFS_MDLY = 6'h10;
  localparam logic [5:0] OFS_CMD = 6'h14;
  localparam logic [5:0] OFS_WSTAT = 6'h18;
  localparam logic [5:0] OFS_USED = 6'h1c;
  localparam logic [5:0] OFS_FNUM = 6'h20;
  localparam logic [5:0] OFS_FSTAT = 6'h24;
  localparam logic [5:0] OFS_FSEL = 6'h28;
  localparam logic [5:0] OFS_FTTT = 6'h2c;
  localparam logic [5:0] OFS_FDUR = 6'h30;
  localparam logic [5:0] OFS_FMEAS = 6'h34;
  localparam logic [5:0] OFS_FNO = 6'h38;

  typedef enum logic [1:0] {
    ST_ARM = 2'b00,
    ST_EVT = 2'b01,
    ST_POST = 2'b11,
    ST_HOLD = 2'b10
  } dfr_wst_e;

  typedef struct packed {
    logic [5:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } dfr_avs_req_s;

  typedef struct packed {
    logic on;
    logic start;
    logic store;
    dfr_wst_e sec;
    logic [15:0] fno;
    logic [15:0] gno;
  } dfr_wave_s;

  typedef struct packed {
    logic [15:0] fno;
    logic [15:0] gno;
    logic [TW-1:0] dur;
    logic [TW-1:0] ttt;
    logic ttt_ok;
    logic tripped;
    logic [15:0] meas;
  } dfr_entry_s;

  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic ovw;
    logic trips_only;
    logic [NTRIG-1:0] trig_en;
    logic [TW-1:0] len;
    logic [6:0] pre_pct;
    logic [6:0] post_pct;
    logic [TW-1:0] mdly;
    dfr_wst_e st;
    logic [NTRIG-1:0] cause;
    logic [TW-1:0] cnt;
    logic [TW-1:0] pcnt;
    logic [TW-1:0] pfill;
    logic [31:0] used;
    logic man;
    dfr_wave_s wave;
    logic gp;
    logic tseen;
    logic mwait;
    logic [TW-1:0] mcnt;
    logic [TW-1:0] ttt;
    logic [TW-1:0] dur;
    logic [15:0] meas;
    logic [FIDW-1:0] pid;
    logic [FIDW-1:0] tid;
    logic [15:0] fno;
    logic [15:0] gno;
    logic [4:0] wp;
    logic [4:0] fcnt;
    logic popup;
    logic [4:0] sel;
    logic nv_we;
    dfr_entry_s nv;
    dfr_entry_s [FDEPTH-1:0] fifo;
  } dfr_state_s;
endpackage

/* src/dfr_top.sv */
// Disturbance and fault recorder control with Avalon-MM registers
//
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
// What this block does
// R1: Sample store strobe follows every sample tick, 32 per power cycle.
// R2: Eight enabled trigger sources are ORed; any one starts a record.
// R3: No new record until all sources that caused the last have dropped.
// R4: Storage accounting holds 120 s of ticks; record count varies.
// R5: Maximum record length is clamped to 15 s, pre and post included.
// R6: Pre and post lengths are percentages times the maximum length.
// R7: A record starts only with a full pre-trigger section available.
// R8: Event section lasts while trigger holds, at most length minus pre.
// R9: Post section is min of post setting and time left; may be zero.
// R10: Recording always stops once the maximum length has elapsed.
// R11: When full, overwrite oldest or refuse records until cleared.
// R12: A manual trigger command also starts a record.
// R13: Fault recorder starts on rising edge of OR of all pickups.
// R14: General trip is the OR of all trip outputs.
// R15: Measurements latch at trip or after a delay counted from trip.
// R16: Record mode selects all pickups or only tripped faults.
// R17: Popup raised when general pickup falls, showing newest record.
// R18: Time to trip from first pickup to first trip; void if modules differ.
// R19: Fault duration runs from pickup rise to its next fall.
// R20: Fault store keeps 20 entries, overwriting oldest first.
// R21: Newest fault record is pushed out to non-volatile storage.
// R22: Each fault record flags whether the fault tripped.
// R23: Waveform and fault records carry the same fault and grid numbers; a record started in the cycle pickup rises takes the previous numbers.
// R24: Fault number counts every pickup; grid number skips reclosing.
// R25: All durations are counted in sample ticks.
module dfr_top import dfr_pkg::*; #(
  parameter int CAP_TICKS_P = CAP_TICKS,
  parameter int MAX_TICKS_P = MAX_TICKS
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire dfr_avs_req_s avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sample_tick,
  input wire logic [NTRIG-1:0] trig_src,
  input wire logic [NFUNC-1:0] pickup,
  input wire logic [NFUNC-1:0] trip,
  input wire logic ar_active,
  input wire logic [15:0] meas_in,
  output dfr_wave_s wave,
  output logic fault_popup,
  output logic nv_we,
  output dfr_entry_s nv_entry
);

  dfr_state_s s;
  dfr_state_s n;
  logic [TW-1:0] pre_len;
  logic [TW-1:0] post_len;
  logic [31:0] rd;
  logic gp_now;
  logic gt_now;
  logic full;
  logic can_start;
  dfr_entry_s ent_rd;

  function automatic logic [FIDW-1:0] lowest(input logic [NFUNC-1:0] v);
    logic [FIDW-1:0] r;
    r = '0;
    for (int i = NFUNC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = FIDW'(i);
      end
    end
    return r;
  endfunction

  // Division by a constant keeps the settings in plain percent
  assign pre_len = TW'((32'(s.len) * 32'(s.pre_pct)) / 32'(PCT_FULL)); // R6
  assign post_len = TW'((32'(s.len) * 32'(s.post_pct)) / 32'(PCT_FULL)); // R6
  assign gp_now = |pickup; // R13
  assign gt_now = |trip; // R14
  assign full = (s.used + 32'(s.len)) > 32'(CAP_TICKS_P); // R4
  assign can_start = ((|(trig_src & s.trig_en)) | s.man) // R2 R12
    & (s.pfill >= pre_len) // R7
    & (!full | s.ovw); // R11
  assign ent_rd = (s.sel < 5'(FDEPTH)) ? s.fifo[s.sel] : '0;

  always_comb begin
    case (avs_req.address)
      OFS_CTRL: rd = {30'h0, s.trips_only, s.ovw};
      OFS_TRIG: rd = {24'h0, s.trig_en};
      OFS_LEN: rd = {8'h0, s.len};
      OFS_PCT: rd = {17'h0, s.post_pct, 1'b0, s.pre_pct};
      OFS_MDLY: rd = {8'h0, s.mdly};
      OFS_WSTAT: rd = {28'h0, full, s.wave.on, s.st};
      OFS_USED: rd = s.used;
      OFS_FNUM: rd = {s.gno, s.fno};
      OFS_FSTAT: rd = {11'h0, s.wp, 3'h0, s.fcnt, 7'h0, s.popup};
      OFS_FSEL: rd = {27'h0, s.sel};
      OFS_FTTT: rd = {6'h0, ent_rd.tripped, ent_rd.ttt_ok, ent_rd.ttt};
      OFS_FDUR: rd = {8'h0, ent_rd.dur};
      OFS_FMEAS: rd = {16'h0, ent_rd.meas};
      OFS_FNO: rd = {ent_rd.gno, ent_rd.fno};
      default: rd = 32'h0;
    endcase
  end

  always_comb begin
    logic fin;
    logic [31:0] tot;
    logic [TW-1:0] c1;
    dfr_entry_s ent;
    fin = 1'b0;
    n = s;
    c1 = s.cnt + 24'h000001;
    tot = s.used + 32'(c1) + 32'(pre_len);
    ent = '0;
    n.wave.start = 1'b0;
    n.wave.store = sample_tick; // R1
    n.nv_we = 1'b0;
    // Waveform recorder sequencing
    case (s.st)
      ST_ARM: begin
        if (sample_tick && s.pfill < pre_len) begin
          n.pfill = s.pfill + 24'h000001; // R7
        end
        if (can_start) begin
          n.st = ST_EVT;
          n.cause = trig_src & s.trig_en; // R3
          n.man = 1'b0; // R12
          n.cnt = '0;
          n.pcnt = '0;
          n.wave.start = 1'b1;
          n.wave.on = 1'b1;
          n.wave.fno = s.fno; // R23
          n.wave.gno = s.gno; // R23
          if (full) begin
            n.used = s.used - 32'(s.len); // R11
          end
        end
      end
      ST_EVT: begin
        if (sample_tick) begin
          n.cnt = c1; // R25
          if (!(|(trig_src & s.cause)) || c1 + pre_len >= s.len) begin // R8
            if (post_len == '0 || c1 + pre_len >= s.len) begin // R9
              fin = 1'b1;
            end else begin
              n.st = ST_POST;
            end
          end
        end
      end
      ST_POST: begin
        if (sample_tick) begin
          n.cnt = c1;
          n.pcnt = s.pcnt + 24'h000001;
          if (n.pcnt >= post_len || c1 + pre_len >= s.len) begin // R9 R10
            fin = 1'b1;
          end
        end
      end
      ST_HOLD: begin
        if (!(|(trig_src & s.cause))) begin // R3
          n.st = ST_ARM;
        end
      end
      default: n.st = ST_ARM;
    endcase
    if (fin) begin
      n.st = ST_HOLD;
      n.wave.on = 1'b0;
      n.used = (tot > 32'(CAP_TICKS_P)) ? 32'(CAP_TICKS_P) : tot; // R4
    end
    n.wave.sec = n.st;
    // Bus slave: one wait cycle, then the access completes
    n.waitreq = 1'b1;
    if ((avs_req.read || avs_req.write) && s.waitreq) begin
      n.waitreq = 1'b0;
      n.rdata = rd;
    end
    if (avs_req.write && !s.waitreq) begin
      case (avs_req.address)
        OFS_CTRL: begin
          n.ovw = avs_req.writedata[0];
          n.trips_only = avs_req.writedata[1];
        end
        OFS_TRIG: n.trig_en = avs_req.writedata[NTRIG-1:0];
        OFS_LEN: begin
          if (avs_req.writedata[TW-1:0] > TW'(MAX_TICKS_P)) begin
            n.len = TW'(MAX_TICKS_P); // R5
          end else begin
            n.len = avs_req.writedata[TW-1:0];
          end
        end
        OFS_PCT: begin
          n.pre_pct = avs_req.writedata[6:0];
          n.post_pct = avs_req.writedata[14:8];
        end
        OFS_MDLY: n.mdly = avs_req.writedata[TW-1:0];
        OFS_CMD: begin
          if (avs_req.writedata[0]) begin
            n.man = 1'b1; // R12
          end
          if (avs_req.writedata[1]) begin
            n.used = '0; // R11
          end
          if (avs_req.writedata[2]) begin
            n.popup = 1'b0;
          end
        end
        OFS_FSEL: n.sel = avs_req.writedata[4:0];
        default: ;
      endcase
    end
    // Fault recorder; runs after the bus so a new fault beats an ack
    n.gp = gp_now;
    if (gp_now && !s.gp) begin
      n.fno = s.fno + 16'h0001; // R24
      if (!ar_active) begin
        n.gno = s.gno + 16'h0001; // R24
      end
      n.dur = '0;
      n.ttt = '0;
      n.tseen = 1'b0;
      n.mwait = 1'b0;
      n.meas = '0;
      n.pid = lowest(pickup); // R13
    end else if (s.gp && sample_tick) begin
      n.dur = s.dur + 24'h000001; // R19 R25
      if (!s.tseen) begin
        n.ttt = s.ttt + 24'h000001; // R18
      end
    end
    if (s.gp && gp_now && gt_now && !s.tseen) begin
      n.tseen = 1'b1;
      n.tid = lowest(trip);
      if (s.mdly == '0) begin
        n.meas = meas_in; // R15
      end else begin
        n.mwait = 1'b1;
        n.mcnt = '0;
      end
    end
    if (s.mwait) begin
      if (s.mcnt >= s.mdly) begin
        n.meas = meas_in; // R15
        n.mwait = 1'b0;
      end else if (sample_tick) begin
        n.mcnt = s.mcnt + 24'h000001;
      end
    end
    if (!gp_now && s.gp && (s.tseen || !s.trips_only)) begin // R16
      ent.fno = s.fno;
      ent.gno = s.gno;
      ent.dur = s.dur; // R19
      ent.ttt_ok = s.tseen && (s.pid == s.tid); // R18
      ent.ttt = ent.ttt_ok ? s.ttt : '0;
      ent.tripped = s.tseen; // R22
      ent.meas = s.meas;
      n.fifo[s.wp] = ent; // R20
      n.wp = (s.wp == 5'(FDEPTH - 1)) ? 5'h00 : s.wp + 5'h01; // R20
      if (s.fcnt < 5'(FDEPTH)) begin
        n.fcnt = s.fcnt + 5'h01;
      end
      n.popup = 1'b1; // R17
      n.nv_we = 1'b1; // R21
      n.nv = ent; // R21
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s <= '0;
      s.waitreq <= 1'b1;
      s.len <= LEN_RST;
      s.pre_pct <= PRE_RST;
      s.post_pct <= POST_RST;
      s.st <= ST_ARM;
    end else if (clk_en) begin
      s <= n;
    end
  end

  assign avs_readdata = s.rdata;
  assign avs_waitrequest = s.waitreq;
  assign wave = s.wave;
  assign fault_popup = s.popup;
  assign nv_we = s.nv_we;
  assign nv_entry = s.nv;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_gp_rise;
    clk_en && gp_now && !s.gp;
  endsequence
  sequence s_gp_fall;
    clk_en && !gp_now && s.gp;
  endsequence
  sequence s_first_trip;
    clk_en && s.gp && gp_now && gt_now && !s.tseen;
  endsequence

  property p_bus_ans;
    clk_en && (avs_req.read || avs_req.write) && s.waitreq
      |=> !avs_waitrequest;
  endproperty
  a_bus_ans: assert property (p_bus_ans)
    else $error("bus request not answered in one cycle");

  property p_trig_start;
    clk_en && s.st == ST_ARM && can_start |=> wave.start && wave.on;
  endproperty
  a_trig_start: assert property (p_trig_start) // R2
    else $error("trigger did not start a record");

  property p_rearm;
    s.st == ST_HOLD && (|(trig_src & s.cause)) |=> s.st == ST_HOLD;
  endproperty
  a_rearm: assert property (p_rearm) // R3
    else $error("rearmed while a causing source is active");

  property p_len_stop;
    wave.on |-> s.cnt + pre_len <= s.len;
  endproperty
  a_len_stop: assert property (p_len_stop) // R10
    else $error("record ran past its maximum length");

  property p_full_refuse;
    clk_en && s.st == ST_ARM && full && !s.ovw |=> !wave.start;
  endproperty
  a_full_refuse: assert property (p_full_refuse) // R11
    else $error("record started with storage full");

  property p_fno;
    s_gp_rise |=> s.fno == $past(s.fno) + 16'h0001;
  endproperty
  a_fno: assert property (p_fno) // R24
    else $error("fault number did not advance on pickup");

  property p_popup;
    s_gp_fall ##0 !s.trips_only |=> fault_popup && nv_we
      ##1 (!nv_we || !$past(clk_en));
  endproperty
  a_popup: assert property (p_popup) // R17
    else $error("popup or store missing after pickup fell");

  property p_depth;
    s.fcnt <= 5'(FDEPTH) && s.wp < 5'(FDEPTH);
  endproperty
  a_depth: assert property (p_depth) // R20
    else $error("fault store index out of range");

  property p_store;
    clk_en && sample_tick |=> wave.store;
  endproperty
  a_store: assert property (p_store) // R1
    else $error("sample tick not passed to store strobe");

  property p_gno_ar;
    s_gp_rise ##0 ar_active |=> s.gno == $past(s.gno);
  endproperty
  a_gno_ar: assert property (p_gno_ar) // R24
    else $error("grid number advanced during reclosing");

  property p_meas;
    s_first_trip ##0 s.mdly == '0 |=> s.meas == $past(meas_in);
  endproperty
  a_meas: assert property (p_meas) // R15
    else $error("measurement not latched at trip");

  property p_pre_full;
    clk_en && s.st == ST_ARM && s.pfill < pre_len |=> !wave.start;
  endproperty
  a_pre_full: assert property (p_pre_full) // R7
    else $error("record started without full pre section");

  property p_wp_wrap;
    s_gp_fall ##0 (s.tseen || !s.trips_only) ##0 s.wp == 5'(FDEPTH - 1)
      |=> s.wp == 5'h00;
  endproperty
  a_wp_wrap: assert property (p_wp_wrap) // R20
    else $error("fault store pointer did not wrap");
endmodule

/* sim/dfr_prot_model.sv */
// Protection pickup, trip and sampler model for the recorder bench
`timescale 1ns/1ps
module dfr_prot_model import dfr_pkg::*; #(
  parameter int TICK_DIV = 4
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [NFUNC-1:0] pu_cmd,
  input wire logic [NFUNC-1:0] tr_cmd,
  input wire logic [15:0] meas_cmd,
  output logic sample_tick,
  output logic [NFUNC-1:0] pickup,
  output logic [NFUNC-1:0] trip,
  output logic [15:0] meas_in
);
  int div = 0;
  // Timebase runs free, also in reset, like a real sampler
  always_ff @(posedge ref_clk) begin
    div <= (div + 1) % TICK_DIV;
    sample_tick <= (div == TICK_DIV - 1);
    pickup <= rst_b ? pu_cmd : '0;
    trip <= rst_b ? tr_cmd : '0;
    meas_in <= meas_cmd;
  end
endmodule

/* sim/tb.sv */
// Self-checking bench for the recorder control
`timescale 1ns/1ps
module tb;
  import dfr_pkg::*;
  localparam int CAPT = 200;
  localparam int MAXT = 500;
  localparam int LEN = 40;
  logic ref_clk = 0;
  logic rst_b = 0;
  dfr_avs_req_s avs_req = '0;
  logic [31:0] avs_readdata, q, w_num;
  logic avs_waitrequest, sample_tick, fault_popup, nv_we;
  logic ar_active = 0;
  logic tick_d = 0;
  logic clk_en = 1;
  logic [NTRIG-1:0] trig_src = '0;
  logic [NFUNC-1:0] pickup, trip;
  logic [NFUNC-1:0] pu_cmd = '0;
  logic [NFUNC-1:0] tr_cmd = '0;
  logic [15:0] meas_in, m_exp;
  logic [15:0] meas_cmd = '0;
  dfr_wave_s wave;
  dfr_entry_s nv_entry, last_nv;
  int failures = 0, comparisons = 0, n_start = 0, n_post = 0, n_on = 0;
  int n_nv = 0, store_bad = 0;
  always #2 ref_clk = ~ref_clk;
  dfr_top #(.CAP_TICKS_P(CAPT), .MAX_TICKS_P(MAXT)) dfr_top_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .avs_req(avs_req),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sample_tick(sample_tick), .trig_src(trig_src), .pickup(pickup),
    .trip(trip), .ar_active(ar_active), .meas_in(meas_in), .wave(wave),
    .fault_popup(fault_popup), .nv_we(nv_we), .nv_entry(nv_entry));
  dfr_prot_model dfr_prot_model_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .pu_cmd(pu_cmd), .tr_cmd(tr_cmd),
    .meas_cmd(meas_cmd), .sample_tick(sample_tick), .pickup(pickup),
    .trip(trip), .meas_in(meas_in));
  // Nonblocking so main-thread reads at the edge see settled counts
  always @(posedge ref_clk) begin
    if (rst_b) begin
      n_start <= n_start + int'(wave.start);
      n_post <= n_post + int'(sample_tick && wave.sec == ST_POST);
      n_on <= n_on + int'(sample_tick && wave.on);
      if (wave.store !== tick_d) store_bad <= store_bad + 1;
      if (nv_we) n_nv <= n_nv + 1;
      if (nv_we) last_nv <= nv_entry;
      if (wave.start) w_num <= {wave.gno, wave.fno};
    end
    tick_d <= clk_en ? rst_b & sample_tick : tick_d;
  end
  function automatic int pct_of(input int p);
    return p * LEN / PCT_FULL;
  endfunction
  function automatic int min2(input int a, input int b);
    return a < b ? a : b;
  endfunction
  task automatic final_report();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    avs_req.address <= a;
    avs_req.writedata <= d;
    avs_req.write <= wr;
    avs_req.read <= !wr;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    q = avs_readdata;
    avs_req.read <= 1'b0;
    avs_req.write <= 1'b0;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      while (sample_tick !== 1'b1) @(posedge ref_clk);
    end
  endtask
  task automatic wait_arm();
    int n;
    n = 0;
    while ((wave.sec !== ST_ARM || wave.on !== 1'b0) && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 2000) failures++;
  endtask
  // Trip, when asked, rises tt ticks after pickup; all drop after dt
  task automatic fault(input int pi, input int ti, input int tt, input int dt);
    m_exp = 16'($urandom);
    meas_cmd <= m_exp;
    ticks(1);
    pu_cmd[pi] <= 1'b1;
    if (ti >= 0) begin
      ticks(tt);
      tr_cmd[ti] <= 1'b1;
      ticks(1);
      meas_cmd <= ~m_exp;
      ticks(dt - tt - 1);
    end else ticks(dt);
    pu_cmd <= '0;
    tr_cmd <= '0;
    ticks(2);
  endtask
  initial begin
    #200000;
    failures++;
    final_report();
  end
  initial begin
    int s, p, o, n, b;
    void'($urandom(32'h1bfc));
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    bus(0, OFS_LEN, 0);
    chk(q, 32'(LEN_RST));
    bus(0, OFS_PCT, 0);
    chk(q, (32'(POST_RST) << 8) | 32'(PRE_RST));
    bus(0, 6'h3c, 0);
    chk(q, 0);
    bus(1, OFS_LEN, 32'hffffff);
    bus(0, OFS_LEN, 0);
    chk(q, MAXT);
    bus(1, OFS_LEN, LEN);
    bus(1, OFS_TRIG, 32'hff);
    bus(1, OFS_MDLY, 0);
    clk_en <= 1'b0;
    s = n_start;
    trig_src[0] <= 1'b1;
    ticks(3);
    trig_src <= '0;
    ticks(1);
    clk_en <= 1'b1;
    chk(n_start - s, 0);
    ticks(pct_of(PRE_RST) + 2);
    s = n_start;
    p = n_post;
    b = $urandom_range(NTRIG - 1);
    trig_src[b] <= 1'b1;
    ticks(5);
    trig_src <= '0;
    wait_arm();
    chk(n_start - s, 1);
    chk(n_post - p, min2(pct_of(POST_RST), LEN - pct_of(PRE_RST) - 5));
    s = n_start;
    p = n_post;
    o = n_on;
    trig_src[b] <= 1'b1;
    ticks(LEN + 20);
    chk(n_start - s, 1);
    chk(n_post - p, 0);
    chk(int'(n_on - o <= LEN), 1);
    trig_src <= '0;
    wait_arm();
    n = n_nv;
    fault(2, 2, 5, 9);
    chk(n_nv - n, 1);
    chk(fault_popup, 1);
    chk(last_nv.ttt, 5);
    chk(last_nv.ttt_ok, 1);
    chk(last_nv.dur, 9);
    chk(last_nv.tripped, 1);
    chk(last_nv.meas, m_exp);
    chk({last_nv.gno, last_nv.fno}, 32'h00010001);
    bus(1, OFS_CMD, 4);
    bus(0, OFS_FSTAT, 0);
    chk(q[0], 0);
    ar_active <= 1'b1;
    fault(1, 3, 2, 6);
    ar_active <= 1'b0;
    chk(last_nv.ttt_ok, 0);
    chk(last_nv.tripped, 1);
    chk({last_nv.gno, last_nv.fno}, 32'h00010002);
    bus(1, OFS_CTRL, 2);
    n = n_nv;
    fault(0, -1, 0, 4);
    chk(n_nv - n, 0);
    bus(1, OFS_CTRL, 0);
    fault(0, -1, 0, 4);
    chk(n_nv - n, 1);
    chk(last_nv.tripped, 0);
    chk({last_nv.gno, last_nv.fno}, 32'h00030004);
    s = n_start;
    bus(1, OFS_CMD, 1);
    ticks(2);
    wait_arm();
    chk(n_start - s, 1);
    chk(w_num, 32'h00030004);
    repeat (FDEPTH) begin
      b = $urandom_range(NFUNC - 1);
      fault(b, b, 1, 2);
    end
    bus(0, OFS_FSTAT, 0);
    chk(q[12:8], FDEPTH);
    chk(q[20:16], (3 + FDEPTH) % FDEPTH);
    repeat (30) begin
      bus(1, OFS_CMD, 1);
      ticks(2);
      wait_arm();
    end
    bus(0, OFS_WSTAT, 0);
    chk(q[3], 1);
    s = n_start;
    bus(1, OFS_CMD, 1);
    ticks(30);
    chk(n_start - s, 0);
    bus(1, OFS_CTRL, 1);
    bus(1, OFS_CMD, 1);
    ticks(2);
    wait_arm();
    chk(int'(n_start - s > 0), 1);
    bus(1, OFS_CTRL, 0);
    bus(1, OFS_CMD, 2);
    bus(0, OFS_WSTAT, 0);
    chk(q[3], 0);
    chk(store_bad, 0);
    final_report();
  end
endmodule
